// ==== rtl/sam_txrx.sv ====
// Purpose: serial transmitter/receiver, async and multiprocessor formats
// Assumes: link_clk_i at 16x bit rate; control bits as plain ports
// Notes:   sync mode uses the internally divided clock on sck_o
`timescale 1ns/1ns
module sam_txrx (
   input  wire logic                       clk_i,
   input  wire logic                       resetn_i,
   input  wire logic                       link_clk_i,
   input  wire logic                       tx_enable_bit_i,
   input  wire logic                       rx_enable_bit_i,
   input  wire sam_pkg::sam_cfg_s          cfg_i,
   input  wire logic                       tx_irq_enable_i,
   input  wire logic                       tx_end_irq_enable_i,
   input  wire logic                       rx_irq_enable_i,
   input  wire logic                       mp_bit_tx_value_i,
   input  wire logic                       tx_wr_i,
   input  wire logic [sam_pkg::DATA_W-1:0] tx_data_i,
   input  wire logic                       rx_rd_i,
   input  wire logic                       err_clr_i,
   input  wire logic                       mp_wait_set_i,
   input  wire logic                       rxd_i,
   output logic                            txd_o,
   output logic                            sck_o,
   output logic                            tx_data_empty_flag_o,
   output logic                            tx_end_flag_o,
   output logic                            rx_full_flag_o,
   output logic                            parity_err_flag_o,
   output logic                            framing_err_flag_o,
   output logic                            overrun_flag_o,
   output logic [sam_pkg::DATA_W-1:0]      rx_data_o,
   output logic                            rx_mpb_o,
   output logic                            mp_skip_o,
   output logic                            tx_empty_irq_o,
   output logic                            tx_end_irq_o,
   output logic                            rx_full_irq_o,
   output logic                            rx_error_irq_o
);
   import sam_pkg::*;

   // ------------------------------------------------------------
   // State records
   // ------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] tx_data_reg;
      logic              tx_data_empty_flag;
      logic              tx_end_flag;
      logic [DATA_W-1:0] xfer;
      logic              xfer_mpb;
      logic              req_t;
      logic              ack_s1;
      logic              ack_s2;
      logic              end_s1;
      logic              end_s2;
      logic              end_q;
      logic              rxe_s1;
      logic              rxe_s2;
      logic              rxe_q;
      logic [DATA_W-1:0] rx_data_reg;
      logic              rx_full_flag;
      logic              parity_err_flag;
      logic              framing_err_flag;
      logic              ovr;
      logic              mpb_rx;
      logic              mp_skip;
   } sam_core_s;

   typedef struct packed {
      logic              te_s1;
      logic              te_s2;
      logic              re_s1;
      logic              re_s2;
      sam_cfg_s          cfg_s1;
      sam_cfg_s          cfg_s2;
      logic              rxd_s1;
      logic              rxd_s2;
      logic              rxd_q;
      logic              req_s1;
      logic              req_s2;
      logic              ack_t;
      logic              end_t;
      sam_tx_e           tx_st;
      logic [3:0]        tx_cnt;
      logic [2:0]        tx_bit;
      logic [DATA_W-1:0] tx_shift_reg;
      logic              tx_extra;
      logic              tx_next;
      logic              txd;
      logic              sck;
      sam_rx_e           rx_st;
      logic [3:0]        rx_cnt;
      logic [2:0]        rx_bit;
      logic [DATA_W-1:0] rx_shift_reg;
      logic              rx_extra;
      sam_rxres_s        res;
      logic              rxe_t;
   } sam_link_s;

   sam_core_s core;
   sam_core_s next_core;
   sam_link_s link;
   sam_link_s next_link;

   function automatic logic parity_of(input logic [DATA_W-1:0] d, input sam_cfg_s c);
      logic [DATA_W-1:0] m;
      m = c.seven_bit ? {1'b0, d[DATA_W-2:0]} : d;
      return (^m) ^ c.parity_odd;
   endfunction

   // ------------------------------------------------------------
   // Core domain: flags, data registers, hand-off
   // ------------------------------------------------------------
   always_comb begin
      logic busy;
      logic end_ev;
      logic rx_ev;
      busy   = 1'b0;
      end_ev = 1'b0;
      rx_ev  = 1'b0;
      next_core = core;
      next_core.ack_s1 = link.ack_t;
      next_core.ack_s2 = core.ack_s1;
      next_core.end_s1 = link.end_t;
      next_core.end_s2 = core.end_s1;
      next_core.end_q  = core.end_s2;
      next_core.rxe_s1 = link.rxe_t;
      next_core.rxe_s2 = core.rxe_s1;
      next_core.rxe_q  = core.rxe_s2;
      busy   = core.req_t != core.ack_s2;
      end_ev = core.end_s2 != core.end_q;
      rx_ev  = core.rxe_s2 != core.rxe_q;

      // Software clears first so that hardware sets win
      if (tx_wr_i) begin
         next_core.tx_data_reg  = tx_data_i;
         next_core.tx_data_empty_flag = 1'b0;
         next_core.tx_end_flag = 1'b0;
      end
      if (!tx_enable_bit_i) begin
         next_core.tx_data_empty_flag = 1'b1;
      end else if (!core.tx_data_empty_flag && !busy) begin
         next_core.xfer     = core.tx_data_reg;
         next_core.xfer_mpb = mp_bit_tx_value_i;
         next_core.req_t    = ~core.req_t;
         next_core.tx_data_empty_flag     = 1'b1;
      end
      if (end_ev && tx_enable_bit_i && core.tx_data_empty_flag && !busy) begin
         next_core.tx_end_flag = 1'b1;
      end

      if (rx_rd_i) begin
         next_core.rx_full_flag = 1'b0;
      end
      if (err_clr_i) begin
         next_core.parity_err_flag = 1'b0;
         next_core.framing_err_flag = 1'b0;
         next_core.ovr = 1'b0;
      end
      if (mp_wait_set_i) begin
         next_core.mp_skip = 1'b1;
      end
      // Flags are untouched by the receive enable itself
      if (rx_ev) begin
         if (core.parity_err_flag || core.framing_err_flag || core.ovr) begin
            next_core.rx_full_flag = next_core.rx_full_flag;
         end else if (cfg_i.mp_fmt && core.mp_skip && !link.res.mp_flag_bit) begin
            next_core.mp_skip = 1'b1;
         end else if (core.rx_full_flag && !rx_rd_i) begin
            next_core.ovr = 1'b1;
         end else begin
            next_core.rx_data_reg    = link.res.data;
            next_core.rx_full_flag   = 1'b1;
            next_core.parity_err_flag    = link.res.perr;
            next_core.framing_err_flag    = link.res.ferr;
            next_core.mpb_rx = link.res.mp_flag_bit;
            if (link.res.mp_flag_bit) begin
               next_core.mp_skip = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         core      <= '0;
         core.tx_data_empty_flag <= TX_DATA_EMPTY_FLAG_RST;
         core.tx_end_flag <= TX_END_FLAG_RST;
      end else begin
         core <= next_core;
      end
   end

   // ------------------------------------------------------------
   // Link domain: transmit and receive shifters
   // ------------------------------------------------------------
   always_comb begin
      logic       pend;
      logic       enter_stop;
      logic       load;
      logic       finish_rx;
      logic [2:0] lastb;
      logic [DATA_W-1:0] rdata;
      pend       = 1'b0;
      enter_stop = 1'b0;
      load       = 1'b0;
      finish_rx  = 1'b0;
      lastb      = 3'h0;
      rdata      = '0;
      next_link = link;
      next_link.te_s1  = tx_enable_bit_i;
      next_link.te_s2  = link.te_s1;
      next_link.re_s1  = rx_enable_bit_i;
      next_link.re_s2  = link.re_s1;
      next_link.cfg_s1 = cfg_i;
      next_link.cfg_s2 = link.cfg_s1;
      next_link.rxd_s1 = rxd_i;
      next_link.rxd_s2 = link.rxd_s1;
      next_link.rxd_q  = link.rxd_s2;
      next_link.req_s1 = core.req_t;
      next_link.req_s2 = link.req_s1;
      pend  = link.req_s2 != link.ack_t;
      lastb = (link.cfg_s2.seven_bit && !link.cfg_s2.sync_mode) ? LAST_BIT7 : LAST_BIT8;

      // ---------------- transmitter ----------------
      if (!link.te_s2) begin
         next_link.tx_st  = TX_IDLE;
         next_link.tx_cnt = 4'h0;
         next_link.txd    = LINE_IDLE;
         next_link.sck    = 1'b1;
         next_link.ack_t  = link.req_s2;
      end else begin
         next_link.tx_cnt = link.tx_cnt + 4'h1;
         case (link.tx_st)
            TX_IDLE: begin
               next_link.tx_cnt = 4'h0;
               next_link.sck    = 1'b1;
               if (pend) begin
                  load = 1'b1;
                  next_link.tx_bit = 3'h0;
                  if (link.cfg_s2.sync_mode) begin
                     next_link.tx_st = TX_DATA;
                     next_link.txd   = core.xfer[0];
                  end else begin
                     next_link.tx_st = TX_START;
                     next_link.txd   = 1'b0;
                  end
               end else if (!link.cfg_s2.sync_mode) begin
                  next_link.txd = LINE_IDLE;
               end
            end
            TX_START: begin
               if (link.tx_cnt == OVS_LAST) begin
                  next_link.tx_st  = TX_DATA;
                  next_link.tx_bit = 3'h0;
                  next_link.txd    = link.tx_shift_reg[0];
               end
            end
            TX_DATA: begin
               if (link.cfg_s2.sync_mode) begin
                  next_link.sck = next_link.tx_cnt[3];
               end
               if (link.tx_cnt == OVS_LAST) begin
                  if (link.tx_bit != lastb) begin
                     next_link.tx_shift_reg    = link.tx_shift_reg >> 1;
                     next_link.tx_bit = link.tx_bit + 3'h1;
                     next_link.txd    = link.tx_shift_reg[1];
                  end else if (link.cfg_s2.sync_mode) begin
                     next_link.sck = 1'b1;
                     if (pend) begin
                        load = 1'b1;
                        next_link.tx_bit = 3'h0;
                        next_link.txd    = core.xfer[0];
                     end else begin
                        next_link.tx_st = TX_IDLE;
                        next_link.end_t = ~link.end_t;
                     end
                  end else if (link.cfg_s2.parity_en || link.cfg_s2.mp_fmt) begin
                     next_link.tx_st = TX_EXTRA;
                     next_link.txd   = link.tx_extra;
                  end else begin
                     enter_stop = 1'b1;
                  end
               end
            end
            TX_EXTRA: begin
               if (link.tx_cnt == OVS_LAST) begin
                  enter_stop = 1'b1;
               end
            end
            TX_STOP1: begin
               if (link.tx_cnt == OVS_LAST) begin
                  if (link.cfg_s2.two_stop) begin
                     next_link.tx_st = TX_STOP2;
                  end else if (link.tx_next) begin
                     next_link.tx_st = TX_START;
                     next_link.txd   = 1'b0;
                  end else begin
                     next_link.tx_st = TX_IDLE;
                  end
               end
            end
            TX_STOP2: begin
               if (link.tx_cnt == OVS_LAST) begin
                  next_link.tx_st = link.tx_next ? TX_START : TX_IDLE;
                  next_link.txd   = !link.tx_next;
               end
            end
            default: begin
               next_link.tx_st = TX_IDLE;
            end
         endcase
         if (enter_stop) begin
            next_link.tx_st = TX_STOP1;
            next_link.txd   = 1'b1;
            if (pend) begin
               load = 1'b1;
               next_link.tx_next = 1'b1;
            end else begin
               next_link.tx_next = 1'b0;
               next_link.end_t   = ~link.end_t;
            end
         end
         if (load) begin
            next_link.tx_shift_reg   = core.xfer;
            next_link.ack_t = ~link.ack_t;
            next_link.tx_extra = link.cfg_s2.mp_fmt ? core.xfer_mpb
                                 : parity_of(core.xfer, link.cfg_s2);
         end
      end

      // ---------------- receiver ----------------
      next_link.rx_cnt = link.rx_cnt + 4'h1;
      if (!link.re_s2) begin
         next_link.rx_st  = RX_IDLE;
         next_link.rx_bit = 3'h0;
      end else if (link.cfg_s2.sync_mode) begin
         if (link.tx_st == TX_DATA && link.tx_cnt == SYNC_RISE) begin
            next_link.rx_shift_reg = {link.rxd_s2, link.rx_shift_reg[DATA_W-1:1]};
            next_link.rx_bit = link.rx_bit + 3'h1;
            if (link.rx_bit == LAST_BIT8) begin
               finish_rx = 1'b1;
            end
         end
      end else begin
         case (link.rx_st)
            RX_IDLE: begin
               if (link.rxd_q && !link.rxd_s2) begin
                  next_link.rx_st  = RX_START;
                  next_link.rx_cnt = 4'h0;
               end
            end
            RX_START: begin
               if (link.rx_cnt == OVS_MID) begin
                  next_link.rx_cnt = 4'h0;
                  next_link.rx_bit = 3'h0;
                  next_link.rx_st  = link.rxd_s2 ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (link.rx_cnt == OVS_LAST) begin
                  next_link.rx_shift_reg    = {link.rxd_s2, link.rx_shift_reg[DATA_W-1:1]};
                  next_link.rx_bit = link.rx_bit + 3'h1;
                  if (link.rx_bit == lastb) begin
                     next_link.rx_st = (link.cfg_s2.parity_en || link.cfg_s2.mp_fmt)
                                       ? RX_EXTRA : RX_STOP;
                  end
               end
            end
            RX_EXTRA: begin
               if (link.rx_cnt == OVS_LAST) begin
                  next_link.rx_extra = link.rxd_s2;
                  next_link.rx_st    = RX_STOP;
               end
            end
            RX_STOP: begin
               if (link.rx_cnt == OVS_LAST) begin
                  finish_rx = 1'b1;
                  next_link.rx_st = RX_IDLE;
               end
            end
            default: begin
               next_link.rx_st = RX_IDLE;
            end
         endcase
      end
      if (finish_rx) begin
         rdata = (link.cfg_s2.seven_bit && !link.cfg_s2.sync_mode)
                 ? {1'b0, next_link.rx_shift_reg[DATA_W-1:1]} : next_link.rx_shift_reg;
         next_link.res.data = rdata;
         next_link.res.mp_flag_bit  = link.cfg_s2.mp_fmt && !link.cfg_s2.sync_mode
                              && link.rx_extra;
         next_link.res.perr = link.cfg_s2.parity_en && !link.cfg_s2.mp_fmt
                              && !link.cfg_s2.sync_mode
                              && (parity_of(rdata, link.cfg_s2) != link.rx_extra);
         next_link.res.ferr = !link.cfg_s2.sync_mode && !link.rxd_s2;
         next_link.rxe_t    = ~link.rxe_t;
         next_link.rx_bit   = 3'h0;
      end
   end

   always_ff @(posedge link_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         link        <= '0;
         link.tx_st  <= TX_IDLE;
         link.rx_st  <= RX_IDLE;
         link.txd    <= LINE_IDLE;
         link.sck    <= 1'b1;
         link.rxd_s1 <= LINE_IDLE;
         link.rxd_s2 <= LINE_IDLE;
         link.rxd_q  <= LINE_IDLE;
      end else begin
         link <= next_link;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign txd_o                = link.txd;
   assign sck_o                = link.sck;
   assign tx_data_empty_flag_o = core.tx_data_empty_flag;
   assign tx_end_flag_o        = core.tx_end_flag;
   assign rx_full_flag_o       = core.rx_full_flag;
   assign parity_err_flag_o    = core.parity_err_flag;
   assign framing_err_flag_o   = core.framing_err_flag;
   assign overrun_flag_o       = core.ovr;
   assign rx_data_o            = core.rx_data_reg;
   assign rx_mpb_o             = core.mpb_rx;
   assign mp_skip_o            = core.mp_skip;
   assign tx_empty_irq_o       = core.tx_data_empty_flag && tx_irq_enable_i;
   assign tx_end_irq_o         = core.tx_end_flag && tx_end_irq_enable_i;
   assign rx_full_irq_o        = core.rx_full_flag && rx_irq_enable_i;
   assign rx_error_irq_o       = (core.parity_err_flag || core.framing_err_flag || core.ovr) && rx_irq_enable_i;

endmodule

// ==== rtl/sam_pkg.sv ====
// Purpose: constants and types for the serial async/multiprocessor transmitter-receiver
// Assumes: link clock runs at 16 times the bit rate
// Notes:   shared by the core domain and the link domain
package sam_pkg;

   localparam int          DATA_W     = 8;
   localparam logic [3:0]  OVS_LAST   = 4'hF;
   localparam logic [3:0]  OVS_MID    = 4'h7;
   localparam logic [3:0]  SYNC_RISE  = 4'h8;
   localparam logic [2:0]  LAST_BIT8  = 3'h7;
   localparam logic [2:0]  LAST_BIT7  = 3'h6;
   localparam logic        TX_DATA_EMPTY_FLAG_RST   = 1'b1;
   localparam logic        TX_END_FLAG_RST   = 1'b1;
   localparam logic        LINE_IDLE  = 1'b1;

   typedef struct packed {
      logic sync_mode;
      logic seven_bit;
      logic parity_en;
      logic parity_odd;
      logic mp_fmt;
      logic two_stop;
   } sam_cfg_s;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              mp_flag_bit;
      logic              perr;
      logic              ferr;
   } sam_rxres_s;

   typedef enum logic [2:0] {
      TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP1, TX_STOP2
   } sam_tx_e;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP
   } sam_rx_e;

endpackage

// ==== tb/sam_txrx_chk.sv ====
// Purpose: port assertions for sam_txrx
// Assumes: async formats in the bench, plus one clocked synchronous transmit at the end
// Notes:   all checks on the core clock
`timescale 1ns/1ns
module sam_txrx_chk (
   input wire logic              clk_i,
   input wire logic              resetn_i,
   input wire sam_pkg::sam_cfg_s cfg_i,
   input wire logic              tx_enable_bit_i,
   input wire logic              rx_irq_enable_i,
   input wire logic              tx_wr_i,
   input wire logic              txd_o,
   input wire logic              tx_data_empty_flag_o,
   input wire logic              tx_end_flag_o,
   input wire logic              rx_full_flag_o,
   input wire logic              parity_err_flag_o,
   input wire logic              framing_err_flag_o,
   input wire logic              overrun_flag_o,
   input wire logic [7:0]        rx_data_o,
   input wire logic              rx_error_irq_o
);
   import sam_pkg::*;
   logic errs;
   assign errs = parity_err_flag_o | framing_err_flag_o | overrun_flag_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_te_off; !tx_enable_bit_i |=> tx_data_empty_flag_o; endproperty
   a_te_off: assert property (p_te_off) else $error("empty low, tx off");
   property p_load;
      tx_wr_i && tx_enable_bit_i && tx_end_flag_o |=> !tx_data_empty_flag_o ##1 tx_data_empty_flag_o;
   endproperty
   a_load: assert property (p_load) else $error("no hand-off");
   property p_end; $rose(tx_end_flag_o) && !$past(tx_wr_i) |-> tx_data_empty_flag_o; endproperty
   a_end: assert property (p_end) else $error("end without empty");
   property p_idle; tx_end_flag_o && !cfg_i.sync_mode |-> txd_o; endproperty
   a_idle: assert property (p_idle) else $error("line not at mark");
   property p_eirq; rx_irq_enable_i |-> rx_error_irq_o == errs; endproperty
   a_eirq: assert property (p_eirq) else $error("error irq wrong");
   property p_block; errs |=> !$rose(rx_full_flag_o) && $stable(rx_data_o); endproperty
   a_block: assert property (p_block) else $error("stored after error");
   property p_store;
      $rose(framing_err_flag_o) || $rose(parity_err_flag_o) |-> $rose(rx_full_flag_o);
   endproperty
   a_store: assert property (p_store) else $error("bad byte not stored");
   property p_ovr; $rose(overrun_flag_o) |-> $stable(rx_data_o) && rx_full_flag_o; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun replaced data");
endmodule
bind sam_txrx sam_txrx_chk u_chk (.clk_i, .resetn_i, .cfg_i, .tx_enable_bit_i, .rx_irq_enable_i,
   .tx_wr_i, .txd_o, .tx_data_empty_flag_o, .tx_end_flag_o, .rx_full_flag_o, .parity_err_flag_o,
   .framing_err_flag_o, .overrun_flag_o, .rx_data_o, .rx_error_irq_o);

// ==== tb/sam_remote.sv ====
// Purpose: remote station on the receive line
// Assumes: link clock at 16x bit rate
// Notes:   line rests at mark between frames
`timescale 1ns/1ns
module sam_remote (
   input  wire logic link_clk_i,
   output logic      rxd_o
);
   initial rxd_o = 1'b1;
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge link_clk_i);
         rxd_o <= f[i];
         repeat (15) @(posedge link_clk_i);
      end
      @(posedge link_clk_i);
      rxd_o <= 1'b1;
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for sam_txrx
// Assumes: remote station drives the receive line
// Notes:   frames are read back from txd
`timescale 1ns/1ns
module tb_top;
   import sam_pkg::*;
   typedef struct packed {logic [4:0] c; logic mb; logic [7:0] d;} sam_row_s;
   logic       clk_i = 1'b0;
   logic       lclk  = 1'b0;
   logic       rstn  = 1'b0;
   logic       te = 1'b0, re = 1'b0, mp_bit_tx_value = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0, mpw = 1'b0;
   logic [7:0] wdat  = 8'h00;
   sam_cfg_s   cfg   = '0;
   logic       rxd, txd, empty, tx_end_flag, full, parity_err_flag, framing_err_flag, ovr, mp_flag_bit, skip;
   logic       ien = 1'b1;
   logic       tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq, sck;
   logic [7:0] rdat;
   int         err_count = 0;
   int         check_count = 0;
   sam_row_s   rows [5] = '{'{5'h00, 1'b0, 8'hA5}, '{5'h19, 1'b0, 8'h35},
      '{5'h0C, 1'b0, 8'hC3}, '{5'h0A, 1'b1, 8'h5A}, '{5'h13, 1'b0, 8'h66}};
   always #4 clk_i = ~clk_i;
   initial begin
      #3;
      forever #32 lclk = ~lclk;
   end
   sam_remote rem (.link_clk_i(lclk), .rxd_o(rxd));
   sam_txrx uut (.clk_i(clk_i), .resetn_i(rstn), .link_clk_i(lclk), .tx_enable_bit_i(te),
      .rx_enable_bit_i(re), .cfg_i(cfg), .tx_irq_enable_i(ien), .tx_end_irq_enable_i(ien),
      .rx_irq_enable_i(ien), .mp_bit_tx_value_i(mp_bit_tx_value), .tx_wr_i(wr), .tx_data_i(wdat),
      .rx_rd_i(rd), .err_clr_i(clr), .mp_wait_set_i(mpw), .rxd_i(rxd), .txd_o(txd), .sck_o(sck),
      .tx_data_empty_flag_o(empty), .tx_end_flag_o(tx_end_flag), .rx_full_flag_o(full),
      .parity_err_flag_o(parity_err_flag), .framing_err_flag_o(framing_err_flag), .overrun_flag_o(ovr),
      .rx_data_o(rdat), .rx_mpb_o(mp_flag_bit), .mp_skip_o(skip), .tx_empty_irq_o(tx_empty_irq),
      .tx_end_irq_o(tx_end_irq), .rx_full_irq_o(rx_full_irq), .rx_error_irq_o(rx_error_irq));
   // Frame bits from start to last stop, length in the top nibble
   function automatic logic [15:0] mk(logic [7:0] d, logic [4:0] c, logic mb);
      logic [11:0] f;
      int          n;
      n = c[4] ? 7 : 8;
      f = '1;
      f[0] = 1'b0;
      for (int i = 0; i < n; i++) f[i+1] = d[i];
      if (c[1] | c[3]) f[n+1] = c[1] ? mb : ^(d & {~c[4], 7'h7F}) ^ c[2];
      n = n + 2 + (c[1] | c[3]) + c[0];
      return {n[3:0], f};
   endfunction
   task automatic give_verdict;
      if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(logic [15:0] g, logic [15:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic write(logic [7:0] d);
      @(posedge clk_i);
      wr <= 1'b1;
      wdat <= d;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic pulse(logic [2:0] p);
      @(posedge clk_i);
      {mpw, clr, rd} <= p;
      @(posedge clk_i);
      {mpw, clr, rd} <= 3'b000;
   endtask
   task automatic setup(logic [4:0] c);
      @(posedge clk_i);
      {te, re} <= 2'b00;
      tick(20);
      cfg <= {1'b0, c};
      tick(2);
      {te, re} <= 2'b11;
      tick(20);
   endtask
   // Sample txd mid-bit; ends just past the last sampled bit
   task automatic grab(int n, output logic [11:0] f);
      int k;
      k = 0;
      f = '1;
      while (txd !== 1'b0) begin
         @(negedge lclk);
         k++;
         if (k > 400) begin
            err_count++;
            give_verdict();
         end
      end
      repeat (8) @(negedge lclk);
      for (int i = 0; i < n; i++) begin
         f[i] = txd;
         repeat ((i < n - 1) ? 16 : 9) @(negedge lclk);
      end
   endtask
   task automatic rx(logic [7:0] d, logic [4:0] c, logic mb, logic [11:0] x);
      logic [15:0] e;
      e = mk(d, c, mb);
      rem.send(e[11:0] ^ x, e[15:12]);
      tick(8);
   endtask
   initial begin
      logic [15:0] e;
      logic [11:0] f;
      sam_row_s    r;
      tick(6);
      rstn <= 1'b1;
      tick(40);
      chk({empty, tx_end_flag, full, parity_err_flag, framing_err_flag, ovr, txd, tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq, sck}, 12'hC39);
      foreach (rows[j]) begin
         r = rows[j];
         setup(r.c);
         mp_bit_tx_value <= r.mb;
         e = mk(r.d, r.c, r.mb);
         write(r.d);
         grab(e[15:12], f);
         chk(f, e[11:0]);
         tick(8);
         chk({tx_end_flag, empty}, 2'b11);
         rx(r.d, r.c, r.mb, 12'h000);
         chk({full, parity_err_flag, framing_err_flag, mp_flag_bit, rdat & {~r.c[4], 7'h7F}}, {3'b100, r.mb, r.d});
         pulse(3'b001);
      end
      setup(5'h00);
      write(8'h11);
      tick(4);
      write(8'h22);
      grab(10, f);
      e = mk(8'h11, 5'h00, 1'b0);
      chk({tx_end_flag, txd, f}, {2'b00, e[11:0]});
      grab(10, f);
      e = mk(8'h22, 5'h00, 1'b0);
      chk(f, e[11:0]);
      tick(1);
      te <= 1'b0;
      tick(20);
      write(8'h77);
      tick(400);
      chk({empty, txd}, 2'b11);
      setup(5'h00);
      rx(8'h3C, 5'h00, 1'b0, 12'h200);
      chk({full, parity_err_flag, framing_err_flag, ovr, rdat}, {4'b1010, 8'h3C});
      pulse(3'b001);
      rx(8'h55, 5'h00, 1'b0, 12'h000);
      chk({full, rdat}, {1'b0, 8'h3C});
      pulse(3'b010);
      rx(8'h55, 5'h00, 1'b0, 12'h000);
      chk({full, framing_err_flag, rdat}, {2'b10, 8'h55});
      rx(8'h99, 5'h00, 1'b0, 12'h000);
      chk({full, ovr, rdat, rx_full_irq, rx_error_irq}, {2'b11, 8'h55, 2'b11});
      ien <= 1'b0;
      tick(2);
      chk({tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq}, 4'h0);
      ien <= 1'b1;
      pulse(3'b011);
      setup(5'h08);
      rx(8'h0F, 5'h08, 1'b0, 12'h200);
      chk({full, parity_err_flag, framing_err_flag, rdat}, {3'b110, 8'h0F});
      tick(1);
      re <= 1'b0;
      tick(40);
      chk({full, parity_err_flag, rdat}, {2'b11, 8'h0F});
      pulse(3'b011);
      setup(5'h02);
      pulse(3'b100);
      rx(8'h42, 5'h02, 1'b0, 12'h000);
      chk({full, skip}, 2'b01);
      rx(8'h07, 5'h02, 1'b1, 12'h000);
      chk({full, mp_flag_bit, skip, rdat}, {3'b110, 8'h07});
      // Clocked synchronous transmit: no start or stop, MSB held after
      {te, re} <= 2'b00;
      tick(20);
      cfg <= 6'h20;
      tick(2);
      te <= 1'b1;
      tick(20);
      write(8'hB4);
      grab(8, f);
      chk(f, 12'hFB4);
      tick(8);
      chk({tx_end_flag, txd, sck}, 3'b111);
      give_verdict();
   end
endmodule
